// [sccal_apb_slave.sv]
// apb slave decode: zero wait states, error on unmapped address
// assumes addresses are byte addresses in a 14-bit window
`timescale 1ns/100ps
module sccal_apb_slave (
  input wire logic [13:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  output logic o_wr_cf,
  output logic o_wr_dcu,
  output logic o_sel_cf,
  output logic o_sel_dcu,
  output logic o_err
);
  wire logic access = i_psel & i_penable;
  wire logic hit_cf = (i_paddr == sccal_pkg::CF_ADDR);
  wire logic hit_dcu = (i_paddr == sccal_pkg::DCU_ADDR);
  assign o_sel_cf = hit_cf;
  assign o_sel_dcu = hit_dcu;
  assign o_wr_cf = access & i_pwrite & hit_cf;
  assign o_wr_dcu = access & i_pwrite & hit_dcu;
  assign o_err = access & ~hit_cf & ~hit_dcu;
endmodule // sccal_apb_slave

// [sccal_cal_timer.sv]
// one calibration loop: start pulse runs a fixed-length count
// assumes start is ignored while a run is in progress
`timescale 1ns/100ps
module sccal_cal_timer #(
  parameter logic [10:0] CYCLES = 11'h001
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  sccal_pkg::sccal_state_type state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  wire logic cnt_end = (cnt_q == (CYCLES - 11'h001));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      sccal_pkg::CAL_IDLE: begin
        cnt_d = 11'h000;
        if (i_start) begin
          state_d = sccal_pkg::CAL_RUN;
        end
      end
      sccal_pkg::CAL_RUN: begin
        cnt_d = cnt_q + 11'h001;
        if (cnt_end) begin
          state_d = sccal_pkg::CAL_DONE;
        end
      end
      sccal_pkg::CAL_DONE: begin
        state_d = sccal_pkg::CAL_IDLE;
      end
      default: begin
        state_d = sccal_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= sccal_pkg::CAL_IDLE;
      cnt_q <= 11'h000;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_busy = (state_q == sccal_pkg::CAL_RUN);
  assign o_done = (state_q == sccal_pkg::CAL_DONE);
endmodule // sccal_cal_timer

// [sccal_chk.sv]
// checker: start and status read of both calibrations, exact cf run length, dcu maximum run length
// assumes bind to sccal_top with I_CE held high
`timescale 1ns/100ps
module sccal_chk (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [13:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_CF_CAL_BUSY,
  input wire logic O_DCU_CAL_BUSY
);
  logic [10:0] cn_q;
  logic [10:0] dn_q;
  wire go = I_PSEL && I_PENABLE && I_PWRITE && I_PWDATA[7];
  wire rs = I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == sccal_pkg::CF_ADDR;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  // busy cycles so far; busy is low in reset
  always_ff @(posedge I_CLOCK) begin
    cn_q <= O_CF_CAL_BUSY ? cn_q + 11'h001 : 11'h000;
    dn_q <= O_DCU_CAL_BUSY ? dn_q + 11'h001 : 11'h000;
  end
  property p_cf_go;
    go && I_PADDR == sccal_pkg::CF_ADDR && !O_CF_CAL_BUSY |-> ##[1:2] O_CF_CAL_BUSY;
  endproperty
  a_cf_go: assert property (p_cf_go) else $error("cf no start");
  property p_cf_len;
    $fell(O_CF_CAL_BUSY) |-> cn_q == 11'h2BC;
  endproperty
  a_cf_len: assert property (p_cf_len) else $error("cf length");
  property p_dcu_go;
    go && I_PADDR == sccal_pkg::DCU_ADDR && !O_DCU_CAL_BUSY |-> ##[1:2] O_DCU_CAL_BUSY;
  endproperty
  a_dcu_go: assert property (p_dcu_go) else $error("dcu no start");
  property p_dcu_len;
    O_DCU_CAL_BUSY |-> dn_q < 11'h078;
  endproperty
  a_dcu_len: assert property (p_dcu_len) else $error("dcu too long");
  property p_cf_bit;
    rs && O_CF_CAL_BUSY |=> O_PRDATA[7];
  endproperty
  a_cf_bit: assert property (p_cf_bit) else $error("cf bit low");
  property p_dcu_bit;
    I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == sccal_pkg::DCU_ADDR && O_DCU_CAL_BUSY
      |=> O_PRDATA[7];
  endproperty
  a_dcu_bit: assert property (p_dcu_bit) else $error("dcu bit low");
endmodule // sccal_chk
bind sccal_top sccal_chk i_sccal_chk (.I_CLOCK, .I_SRST, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .I_PWDATA, .O_PRDATA, .O_CF_CAL_BUSY, .O_DCU_CAL_BUSY);

// [sccal_pkg.sv]
// package for the synthesizer calibration control block
// assumes a 20 MHz system clock and a 32-bit apb register bus
package sccal_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CF_TIME_US = 35;
  localparam int DCU_TIME_US = 6;
  localparam int CF_CYCLES = (CF_TIME_US * (CLK_HZ / 1000000));
  localparam int DCU_CYCLES = (DCU_TIME_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 11;

  localparam logic [11:0] CF_INDEX = 12'h15A;
  localparam logic [11:0] DCU_INDEX = 12'h15B;
  localparam logic [13:0] CF_ADDR = {CF_INDEX, 2'b00};
  localparam logic [13:0] DCU_ADDR = {DCU_INDEX, 2'b00};

  localparam int START_BIT = 7;
  localparam logic [6:0] CF_RES_RESET = 7'h57;
  localparam logic [6:0] DCU_RES_RESET = 7'h20;
  localparam logic [6:0] DCU_RES_WMASK = 7'h3F;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } sccal_apb_req_type;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } sccal_state_type;
endpackage

// [sccal_top.sv]
// top of the synthesizer calibration control: two 8-bit registers over apb
// assumes synchronous reset, one clock, clock enable freezing all state
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module sccal_top (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [13:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_CF_CAL_BUSY,
  output logic O_DCU_CAL_BUSY
);
  sccal_pkg::sccal_apb_req_type req;
  assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                 paddr: I_PADDR, pwdata: I_PWDATA};

  logic wr_cf, wr_dcu, sel_cf, sel_dcu, err;
  logic cf_busy, cf_done, dcu_busy, dcu_done;
  logic cf_start_q, cf_start_d, dcu_start_q, dcu_start_d;
  logic [6:0] cf_res_q, cf_res_d, dcu_res_q, dcu_res_d;

  sccal_apb_slave u_apb (
    .i_paddr(req.paddr),
    .i_psel(req.psel),
    .i_penable(req.penable),
    .i_pwrite(req.pwrite),
    .o_wr_cf(wr_cf),
    .o_wr_dcu(wr_dcu),
    .o_sel_cf(sel_cf),
    .o_sel_dcu(sel_dcu),
    .o_err(err)
  );

  // a write of 1 while idle launches a run; while running it is ignored
  wire logic wdata_start = req.pwdata[sccal_pkg::START_BIT];
  wire logic cf_launch = wr_cf & wdata_start & ~cf_start_q;
  wire logic dcu_launch = wr_dcu & wdata_start & ~dcu_start_q;

  sccal_cal_timer #(
    .CYCLES(11'(sccal_pkg::CF_CYCLES))
  ) u_cf_timer (
    .i_clk(I_CLOCK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(cf_launch),
    .o_busy(cf_busy),
    .o_done(cf_done)
  );

  sccal_cal_timer #(
    .CYCLES(11'(sccal_pkg::DCU_CYCLES))
  ) u_dcu_timer (
    .i_clk(I_CLOCK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(dcu_launch),
    .o_busy(dcu_busy),
    .o_done(dcu_done)
  );

  // software cannot clear a running start bit; only completion does
  assign cf_start_d = cf_done ? 1'b0 : (cf_start_q | cf_launch);
  assign dcu_start_d = dcu_done ? 1'b0 : (dcu_start_q | dcu_launch);
  assign cf_res_d = wr_cf ? req.pwdata[6:0] : cf_res_q;
  // bit 6 of the delay-cell register is read-only
  assign dcu_res_d = wr_dcu ?
    ((req.pwdata[6:0] & sccal_pkg::DCU_RES_WMASK) | (dcu_res_q & ~sccal_pkg::DCU_RES_WMASK)) :
    dcu_res_q;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      cf_start_q <= 1'b0;
      dcu_start_q <= 1'b0;
      cf_res_q <= sccal_pkg::CF_RES_RESET;
      dcu_res_q <= sccal_pkg::DCU_RES_RESET;
    end else if (I_CE) begin
      cf_start_q <= cf_start_d;
      dcu_start_q <= dcu_start_d;
      cf_res_q <= cf_res_d;
      dcu_res_q <= dcu_res_d;
    end
  end

  // read data is registered so it comes from flip-flops
  wire logic [31:0] rd_mux = sel_cf ? {24'h000000, cf_start_q, cf_res_q} :
                             sel_dcu ? {24'h000000, dcu_start_q, dcu_res_q} :
                             32'h00000000;
  logic [31:0] prdata_q;
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      prdata_q <= 32'h00000000;
    end else if (I_CE & req.psel & ~req.penable & ~req.pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // frozen clock enable also stalls the bus so no access is half done
  assign O_PREADY = I_CE;
  assign O_PSLVERR = err & I_CE;
  assign O_PRDATA = prdata_q;
  assign O_CF_CAL_BUSY = cf_busy;
  assign O_DCU_CAL_BUSY = dcu_busy;
endmodule // sccal_top

// [testbench.sv]
// testbench: apb runs of both calibrations and an unmapped read
// assumes a zero-wait slave; I_CE held high
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  sccal_pkg::sccal_apb_req_type req = '0;
  logic [31:0] rd;
  logic [31:0] rdv;
  logic ready;
  logic slverr;
  logic perr;
  int err_total = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  sccal_top i_sccal_top (.I_CLOCK(clk), .I_SRST(srst), .I_CE(1'b1), .I_PSEL(req.psel),
    .I_PENABLE(req.penable), .I_PWRITE(req.pwrite), .I_PADDR(req.paddr),
    .I_PWDATA(req.pwdata), .O_PRDATA(rd), .O_PREADY(ready), .O_PSLVERR(slverr),
    .O_CF_CAL_BUSY(), .O_DCU_CAL_BUSY());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    rdv = rd;
    perr = slverr;
    req <= '0;
    @(posedge clk);
  endtask
  // start, read back while running, poll to completion
  task automatic cal(input logic [13:0] a, input logic [31:0] d, input logic [31:0] rb);
    xfer(1'b1, a, d);
    // a write of 0 to the start bit must not stop the run
    xfer(1'b1, a, d & 32'hFFFFFF7F);
    xfer(1'b0, a, 32'h0);
    check(rdv, rb);
    check({31'h0, perr}, 32'h0);
    while (rdv[7] !== 1'b0) xfer(1'b0, a, 32'h0);
    check(rdv, rb & 32'h7F);
  endtask
  task automatic test_done;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    xfer(1'b0, sccal_pkg::CF_ADDR, 32'h0);
    check(rdv, 32'h57);
    xfer(1'b0, sccal_pkg::DCU_ADDR, 32'h0);
    check(rdv, 32'h20);
    cal(sccal_pkg::DCU_ADDR, 32'hFFFFFFFF, 32'hBF);
    cal(sccal_pkg::CF_ADDR, 32'h80, 32'h80);
    xfer(1'b0, 14'h570, 32'h0);
    check(rdv, 32'h0);
    check({31'h0, perr}, 32'h1);
    test_done();
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule // testbench
